// File: logic/tiop_pkg.sv
// Purpose: shared constants and types of the timed I/O port
// Assumes: core_clk runs at 200 MHz
// Notes: cycle counts are derived from the rates below

// ****************************************************************
// Constants
// ****************************************************************
package tiop_pkg;
  // Clocking of the tile reference clock block
  localparam int CORE_CLK_MHZ = 200;
  localparam int REF_CLK_MHZ = 100;
  localparam int REF_DIV = CORE_CLK_MHZ / REF_CLK_MHZ;
  localparam int NUM_CLKBLK = 6;
  localparam int CLKSEL_W = 3;
  localparam logic [2:0] CLKSEL_RESET = 3'h0;
  localparam int DIV_W = 8;
  localparam logic [7:0] DIV_RESET = 8'h00;
  // Port counter and transfer register
  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam int XFER_W = 32;
  localparam int SLOT_W = 6;
  // Pins pulled down while the device is in reset
  localparam logic PD_RESET = 1'b1;

  // Pin condition that an input waits for
  typedef enum logic [1:0] {
    COND_NONE = 2'b00,
    COND_EQ = 2'b01,
    COND_NE = 2'b10
  } tiop_cond_t;
endpackage

// File: logic/tiop_clk_if.sv
// Purpose: carries clock block setup and port clock ticks
// Assumes: single core_clk domain
// Notes: ticks are one-cycle enables, not clocks

// ****************************************************************
// Clock block carrier
// ****************************************************************
interface tiop_clk_if;
  logic [tiop_pkg::NUM_CLKBLK-1:0] src_ext;
  logic [tiop_pkg::NUM_CLKBLK-1:0][tiop_pkg::DIV_W-1:0] div;
  logic ext_lvl;
  logic [tiop_pkg::NUM_CLKBLK-1:0] tick;

  modport blk (input src_ext, input div, input ext_lvl, output tick);
  modport user (output src_ext, output div, output ext_lvl, input tick);
endinterface

// File: logic/tiop_sync.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to core_clk
// Notes: only the second stage is visible outside

// ****************************************************************
// Synchroniser
// ****************************************************************
module tiop_sync #(
  parameter int SYNC_W = 1
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [SYNC_W-1:0] async_in,
  output logic [SYNC_W-1:0] sync_out
);
  typedef struct packed {
    logic [SYNC_W-1:0] stage1;
    logic [SYNC_W-1:0] stage2;
  } tiop_sync_state_t;

  tiop_sync_state_t s;
  tiop_sync_state_t next_s;

  // First stage feeds only the second
  always_comb begin
    next_s.stage1 = async_in;
    next_s.stage2 = s.stage1;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.stage2;
endmodule

// File: logic/tiop_clkblk.sv
// Purpose: six clock blocks producing port clock ticks
// Assumes: external source level already synchronised
// Notes: block zero is fixed to the reference rate

// ****************************************************************
// Clock blocks
// ****************************************************************
module tiop_clkblk (
  input wire logic core_clk,
  input wire logic rst_b,
  tiop_clk_if.blk cb
);
  localparam int NB = tiop_pkg::NUM_CLKBLK;
  localparam int DW = tiop_pkg::DIV_W;
  localparam logic [DW-1:0] REF_LAST = DW'(tiop_pkg::REF_DIV - 1);

  typedef struct packed {
    logic [DW-1:0] ref_cnt;
    logic ext_prev;
    logic [NB-1:0][DW-1:0] div_cnt;
    logic [NB-1:0] tick;
  } tiop_cb_state_t;

  tiop_cb_state_t s;
  tiop_cb_state_t next_s;
  logic ref_tick;
  logic ext_rise;
  logic src;

  // Reference tick every REF_DIV core cycles; blocks divide a source
  always_comb begin
    next_s = s;
    src = 1'b0;
    ref_tick = (s.ref_cnt == REF_LAST);
    ext_rise = cb.ext_lvl & ~s.ext_prev;
    next_s.ext_prev = cb.ext_lvl;
    next_s.ref_cnt = ref_tick ? '0 : s.ref_cnt + 1'b1;
    next_s.tick = '0;
    next_s.tick[0] = ref_tick;
    for (int i = 1; i < NB; i++) begin
      src = cb.src_ext[i] ? ext_rise : ref_tick;
      if (src) begin
        if (s.div_cnt[i] >= cb.div[i]) begin
          next_s.div_cnt[i] = '0;
          next_s.tick[i] = 1'b1;
        end else begin
          next_s.div_cnt[i] = s.div_cnt[i] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign cb.tick = s.tick;
endmodule

// File: logic/tiop_port.sv
// Purpose: timed I/O port with serialiser, counter and clock blocks
// Assumes: one core_clk domain; pins are asynchronous inputs
// Notes: the port clock is a tick enable from a clock block
//   Pins lost to a link or narrower port read as zero
//   Output pins hold their last slice while idle
//   Time and condition gate only the start of a word
//   A finished input word waits in the serialiser
//   while the transfer register is still full
//   A time set while an output word shifts stays armed; a completing input word disarms it
//   Clock select refuses block numbers above five
//   Open drain outputs need a pull-up on the board
//   Ownership masks are levels, applied every cycle

// ****************************************************************
// Port top
// ****************************************************************
module tiop_port #(
  parameter int PORT_W = 32
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cfg_dir_out,
  input wire logic cfg_open_drain,
  input wire logic cfg_link_en,
  input wire logic [PORT_W-1:0] cfg_pin_taken,
  input wire logic cfg_strobe_in_en,
  input wire logic cfg_strobe_out_en,
  input wire tiop_pkg::tiop_cond_t cfg_cond_mode,
  input wire logic [PORT_W-1:0] cfg_cond_value,
  input wire logic [tiop_pkg::NUM_CLKBLK-1:0] cfg_cb_src_ext,
  input wire logic [tiop_pkg::NUM_CLKBLK-1:0][tiop_pkg::DIV_W-1:0] cfg_cb_div,
  input wire logic cpu_clk_set,
  input wire logic [tiop_pkg::CLKSEL_W-1:0] cpu_clk_value,
  input wire logic cpu_time_set,
  input wire logic [tiop_pkg::CNT_W-1:0] cpu_time_value,
  input wire logic cpu_out_valid,
  input wire logic [tiop_pkg::XFER_W-1:0] cpu_out_data,
  output logic cpu_out_ready,
  output logic cpu_in_valid,
  output logic [tiop_pkg::XFER_W-1:0] cpu_in_data,
  input wire logic cpu_in_ready,
  output logic [tiop_pkg::CNT_W-1:0] port_count,
  output logic [tiop_pkg::CNT_W-1:0] port_stamp,
  output logic port_time_armed,
  output logic [tiop_pkg::CLKSEL_W-1:0] port_clk_sel,
  output logic port_event,
  input wire logic [PORT_W-1:0] pin_in,
  output logic [PORT_W-1:0] pin_out,
  output logic [PORT_W-1:0] pin_oe_b,
  output logic pin_pd_en,
  input wire logic strobe_in,
  output logic strobe_out,
  input wire logic ext_clk_pin
);
  // ****************************************************************
  // Local constants and types
  // ****************************************************************
  localparam int XW = tiop_pkg::XFER_W;
  localparam int CW = tiop_pkg::CNT_W;
  localparam int SW = tiop_pkg::SLOT_W;
  // Slices per word; width must be one of 1,4,8,16,32
  localparam logic [SW-1:0] SLOTS = SW'(XW / PORT_W);
  // Pins, strobe and external clock share one synchroniser
  localparam int SYNC_W = PORT_W + 2;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [CW-1:0] stamp;
    logic [CW-1:0] target;
    logic armed;
    logic [tiop_pkg::CLKSEL_W-1:0] clk_sel;
    logic [XW-1:0] xfer;
    logic xfer_full;
    logic [XW-1:0] sr;
    logic [SW-1:0] slots;
    logic [PORT_W-1:0] drive;
    logic strobe_out;
    logic event_p;
    logic pd_en;
  } tiop_port_state_t;

  tiop_port_state_t s;
  tiop_port_state_t next_s;

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Pin condition test used for start of capture
  function automatic logic cond_hit(
    input tiop_pkg::tiop_cond_t mode,
    input logic [PORT_W-1:0] smp,
    input logic [PORT_W-1:0] val
  );
    logic hit;
    hit = 1'b1;
    unique case (mode)
      tiop_pkg::COND_NONE: hit = 1'b1;
      tiop_pkg::COND_EQ: hit = (smp == val);
      tiop_pkg::COND_NE: hit = (smp != val);
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Mask of pins the port still owns
  function automatic logic [PORT_W-1:0] owned(
    input logic link,
    input logic [PORT_W-1:0] taken
  );
    return ~taken & ~{PORT_W{link}};
  endfunction

  // ****************************************************************
  // Pin ownership
  // ****************************************************************
  logic [PORT_W-1:0] own_mask;

  // Link and narrower ports take pins; the rest stay ours
  assign own_mask = owned(cfg_link_en, cfg_pin_taken);

  // ****************************************************************
  // Synchronisers and clock blocks
  // ****************************************************************
  logic [SYNC_W-1:0] sync_q;
  logic [PORT_W-1:0] pin_sync;
  logic strobe_sync;

  // Pins, ready strobe and external clock pass two flops
  tiop_sync #(
    .SYNC_W(SYNC_W)
  ) u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_in({ext_clk_pin, strobe_in, pin_in}),
    .sync_out(sync_q)
  );

  assign pin_sync = sync_q[PORT_W-1:0];
  assign strobe_sync = sync_q[PORT_W];

  tiop_clk_if clk_bus ();

  // Clock block setup from configuration ports
  assign clk_bus.src_ext = cfg_cb_src_ext;
  assign clk_bus.div = cfg_cb_div;
  assign clk_bus.ext_lvl = sync_q[PORT_W+1];

  tiop_clkblk u_clkblk (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .cb(clk_bus.blk)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic tick;
  logic time_ok;
  logic strobe_ok;
  logic out_fire;
  logic in_fire;
  logic [PORT_W-1:0] sample;
  logic [XW-1:0] shifted;
  logic [XW-1:0] captured;

  // Handshakes are combinational so an access never waits a cycle
  // Trade-off: ready follows cfg_dir_out, which must stay static
  assign cpu_out_ready = cfg_dir_out & ~s.xfer_full;
  assign cpu_in_valid = ~cfg_dir_out & s.xfer_full;
  assign out_fire = cpu_out_valid & cpu_out_ready;
  assign in_fire = cpu_in_valid & cpu_in_ready;

  // One process builds the whole next state
  always_comb begin
    // Every field holds unless a case below moves it
    next_s = s;

    // Event is a one-cycle pulse; pull-down lives only in reset
    next_s.event_p = 1'b0;
    next_s.pd_en = 1'b0;

    // Tick of the clock block this port is attached to
    tick = clk_bus.tick[s.clk_sel];
    // Timed transfer waits for the counter to match
    time_ok = ~s.armed | (s.cnt == s.target);
    // External ready gates the port when enabled
    strobe_ok = ~cfg_strobe_in_en | strobe_sync;
    // Pins lost to a link or narrower port read as zero
    sample = pin_sync & own_mask;

    // New slice enters at the top, so the first one ends lowest
    shifted = s.sr >> PORT_W;
    captured = shifted | (XW'(sample) << (XW - PORT_W));

    // Clock block selection; out of range values ignored
    if (cpu_clk_set && (cpu_clk_value < tiop_pkg::CLKSEL_W'(tiop_pkg::NUM_CLKBLK))) begin
      next_s.clk_sel = cpu_clk_value;
    end

    // Free running port counter, silent wrap
    if (tick) begin
      next_s.cnt = s.cnt + 1'b1;
    end

    // Software arms a future transfer time
    if (cpu_time_set) begin
      next_s.target = cpu_time_value;
      next_s.armed = 1'b1;
    end


    // Direction is static, so only one half is ever live
    if (cfg_dir_out) begin
      // Output: core fills transfer register, serialiser drains it
      if (out_fire) begin
        next_s.xfer = cpu_out_data;
        next_s.xfer_full = 1'b1;
      end
      // Serialiser and pins move only on port ticks
      if (tick) begin
        if (s.slots > 1) begin
          // Next slice of the word in flight
          next_s.sr = shifted;
          next_s.drive = shifted[PORT_W-1:0];
          next_s.slots = s.slots - 1'b1;
          next_s.strobe_out = cfg_strobe_out_en;
        end else if (s.xfer_full && time_ok && strobe_ok) begin
          // Move word to serialiser and stamp it
          next_s.sr = s.xfer;
          next_s.drive = s.xfer[PORT_W-1:0];
          next_s.slots = SLOTS;
          next_s.xfer_full = 1'b0;
          next_s.stamp = s.cnt;
          // A new time set in this cycle outlives the old one
          next_s.armed = cpu_time_set;
          next_s.event_p = 1'b1;
          next_s.strobe_out = cfg_strobe_out_en;
        end else begin
          // Idle: pins keep last value, strobe drops
          next_s.slots = '0;
          next_s.strobe_out = 1'b0;
        end
      end
    end else begin
      // Input: clear first so a completing word still sets full
      // Strobe output belongs to output ports only
      next_s.strobe_out = 1'b0;
      if (in_fire) begin
        next_s.xfer_full = 1'b0;
      end
      // Each port tick, with strobe, takes one slice once a word has started, until it is complete
      if (tick && strobe_ok) begin
        if (s.slots == '0) begin
          // Wait for time and pin condition before capture
          if (time_ok && cond_hit(cfg_cond_mode, sample, cfg_cond_value)) begin
            next_s.sr = captured;
            // First slice is the one that met the condition
            next_s.slots = SW'(1);
            if (cfg_cond_mode != tiop_pkg::COND_NONE) begin
              next_s.event_p = 1'b1;
            end
          end
        end else if (s.slots != SLOTS) begin
          // A finished word holds here until it can move on
          next_s.sr = captured;
          next_s.slots = s.slots + 1'b1;
        end
      end
      // Complete word waits in serialiser while register is busy
      if (s.slots == SLOTS && !s.xfer_full) begin
        next_s.xfer = s.sr;
        next_s.xfer_full = 1'b1;
        next_s.slots = '0;
        next_s.stamp = s.cnt;
        next_s.armed = cpu_time_set;
        next_s.event_p = 1'b1;
      end
    end
  end

  // Hold capture when the finished word cannot move on
  // (slots saturates at SLOTS; tick is ignored meanwhile)

  // ****************************************************************
  // State register
  // ****************************************************************
  // Every field clears first; the named reset values then override
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.cnt <= tiop_pkg::CNT_RESET;
      s.clk_sel <= tiop_pkg::CLKSEL_RESET;
      s.pd_en <= tiop_pkg::PD_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Core side status
  assign cpu_in_data = s.xfer;
  assign port_count = s.cnt;
  assign port_stamp = s.stamp;
  assign port_time_armed = s.armed;
  assign port_clk_sel = s.clk_sel;
  assign port_event = s.event_p;
  assign pin_pd_en = s.pd_en;
  assign strobe_out = s.strobe_out;

  // Open drain never drives a one, it only releases the pin
  assign pin_out = cfg_open_drain ? '0 : s.drive;

  // Enable low while driving; inputs, link and taken pins float
  // Released pins fall to the board pull or the reset pull-down
  always_comb begin
    pin_oe_b = '1;
    for (int i = 0; i < PORT_W; i++) begin
      if (cfg_dir_out && own_mask[i]) begin
        pin_oe_b[i] = cfg_open_drain ? s.drive[i] : 1'b0;
      end
    end
  end
endmodule

// File: testbench/tiop_port_checker.sv
// Purpose: concurrent checks on the timed port
// Assumes: one core_clk domain, bound to tiop_port
// Notes: up_cnt masks history from before reset release
// ****
// Checker
// ****
module tiop_port_checker #(
  parameter int PORT_W = 32
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cfg_dir_out,
  input wire logic cfg_open_drain,
  input wire logic cfg_link_en,
  input wire logic [PORT_W-1:0] cfg_pin_taken,
  input wire logic cpu_clk_set,
  input wire logic [tiop_pkg::CLKSEL_W-1:0] cpu_clk_value,
  input wire logic cpu_time_set,
  input wire logic cpu_out_valid,
  input wire logic cpu_out_ready,
  input wire logic cpu_in_valid,
  input wire logic cpu_in_ready,
  input wire logic [tiop_pkg::CNT_W-1:0] port_count,
  input wire logic [tiop_pkg::CNT_W-1:0] port_stamp,
  input wire logic port_time_armed,
  input wire logic [tiop_pkg::CLKSEL_W-1:0] port_clk_sel,
  input wire logic port_event,
  input wire logic [PORT_W-1:0] pin_out,
  input wire logic [PORT_W-1:0] pin_oe_b,
  input wire logic pin_pd_en
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] up_cnt;
  // Saturating age since reset, so reset-time history is ignored
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      up_cnt <= 3'h0;
    end else if (up_cnt != 3'h7) begin
      up_cnt <= up_cnt + 3'h1;
    end
  end
  default clocking chk_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // Reset state and clock selection
  chk_pd_off: assert property (up_cnt != 3'h0 |-> !pin_pd_en)
    else $error("pull-down left on");
  chk_sel_reset: assert property (up_cnt == 3'h0 |-> port_clk_sel == 3'h0)
    else $error("clock select not zero");
  chk_sel_load: assert property (cpu_clk_set && cpu_clk_value < 3'h6 |=> port_clk_sel == $past(cpu_clk_value))
    else $error("clock select not loaded");
  chk_sel_refuse: assert property (cpu_clk_set && cpu_clk_value > 3'h5 |=> $stable(port_clk_sel))
    else $error("bad clock select taken");
  // Counter steps by one at most and wraps silently
  chk_count_step: assert property (##1 1'b1 |-> port_count == $past(port_count) ||
    port_count == $past(port_count) + 16'h0001)
    else $error("counter jumped");
  chk_ref_rate: assert property (up_cnt == 3'h7 && port_clk_sel == 3'h0 && $past(port_clk_sel) == 3'h0 &&
    $past(port_clk_sel, 2) == 3'h0 |-> port_count == $past(port_count, 2) + 16'h0001)
    else $error("reference tick rate wrong");
  // Core handshakes
  chk_out_taken: assert property (cpu_out_valid && cpu_out_ready |=> !cpu_out_ready)
    else $error("ready held after word taken");
  chk_in_event: assert property ($rose(cpu_in_valid) |-> port_event && !cfg_dir_out)
    else $error("input word without event");
  chk_stamp_evt: assert property ($changed(port_stamp) |-> port_event)
    else $error("stamp moved without transfer");
  chk_time_arm: assert property (cpu_time_set |=> port_time_armed)
    else $error("timed transfer not armed");
  // Pin ownership at each transfer
  chk_pin_owner: assert property (port_event && cfg_dir_out |-> ~|(cfg_pin_taken & ~pin_oe_b))
    else $error("taken pin driven");
  chk_link_off: assert property (port_event && (cfg_link_en || !cfg_dir_out) |-> &pin_oe_b)
    else $error("released pin driven");
  chk_od_low: assert property (port_event && cfg_open_drain && cfg_dir_out |-> ~|pin_out)
    else $error("open drain drives high");
  cov_out: cover property (cpu_out_valid && cpu_out_ready);
  cov_in: cover property (cpu_in_valid && cpu_in_ready);
  cov_timed: cover property ($fell(port_time_armed));
endmodule
bind tiop_port tiop_port_checker #(.PORT_W(PORT_W)) u_chk (.core_clk(core_clk), .rst_b(rst_b),
  .cfg_dir_out(cfg_dir_out), .cfg_open_drain(cfg_open_drain), .cfg_link_en(cfg_link_en),
  .cfg_pin_taken(cfg_pin_taken), .cpu_clk_set(cpu_clk_set), .cpu_clk_value(cpu_clk_value),
  .cpu_time_set(cpu_time_set), .cpu_out_valid(cpu_out_valid), .cpu_out_ready(cpu_out_ready),
  .cpu_in_valid(cpu_in_valid), .cpu_in_ready(cpu_in_ready), .port_count(port_count),
  .port_stamp(port_stamp), .port_time_armed(port_time_armed), .port_clk_sel(port_clk_sel),
  .port_event(port_event), .pin_out(pin_out), .pin_oe_b(pin_oe_b), .pin_pd_en(pin_pd_en));

// File: testbench/tiop_ext_dev.sv
// Purpose: external hardware on the port pins
// Assumes: board pull-up on every pin, device pull-down in reset
// Notes: source clock stands still unless ext_run is high
// ****
// Far side model
// ****
module tiop_ext_dev #(
  parameter int PORT_W = 8
) (
  input wire logic core_clk,
  input wire logic [PORT_W-1:0] pin_out,
  input wire logic [PORT_W-1:0] pin_oe_b,
  input wire logic pin_pd_en,
  input wire logic strobe_out,
  input wire logic [PORT_W-1:0] src_data,
  input wire logic src_en,
  input wire logic rdy_lvl,
  input wire logic ext_run,
  output logic [PORT_W-1:0] pin_wire,
  output logic strobe_in,
  output logic ext_clk_pin,
  output logic [PORT_W-1:0] rx_last
);
  timeunit 1ns;
  timeprecision 100ps;
  // Port drive wins, then ours, then the pulls; no contention modelled
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      if (!pin_oe_b[i]) begin
        pin_wire[i] = pin_out[i];
      end else if (src_en) begin
        pin_wire[i] = src_data[i];
      end else begin
        pin_wire[i] = !pin_pd_en;
      end
    end
  end
  assign strobe_in = rdy_lvl;
  // Source clock of 37 ns, unrelated to core_clk
  initial begin
    ext_clk_pin = 1'b0;
    forever begin
      #18.5;
      ext_clk_pin = ext_run ? !ext_clk_pin : 1'b0;
    end
  end
  // Data is only taken while the port strobes it
  always @(posedge core_clk) begin
    if (strobe_out) begin
      rx_last <= pin_wire;
    end
  end
endmodule

// File: testbench/timed_io_port_with_clock_blocks_test.sv
// Purpose: self-checking bench for the timed I/O port
// Assumes: 8-bit port; block zero ticks every second core cycle
// Notes: rows hold output words; input, timer, clocks hand-written
// ****
// Bench
// ****
module timed_io_port_with_clock_blocks_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PW = 8;
  typedef struct packed {logic [31:0] w; logic odv; logic lk; logic [PW-1:0] tk;} tiop_row_t;
  logic core_clk = 1'b0, rst_b = 1'b0, dir_out = 1'b1, od = 1'b0, link = 1'b0;
  logic s_in_en = 1'b0, s_out_en = 1'b1, clk_set = 1'b0, t_set = 1'b0, o_valid = 1'b0, i_ready = 1'b0;
  logic src_en = 1'b0, rdy = 1'b0, ext_run = 1'b0;
  logic [PW-1:0] taken = 8'h00, cval = 8'h00, src_data = 8'h00;
  tiop_pkg::tiop_cond_t cmode = tiop_pkg::COND_NONE;
  logic [5:0] cb_ext = 6'h00;
  logic [5:0][7:0] cb_div = '0;
  logic [2:0] clk_val = 3'h0;
  logic [15:0] t_val = 16'h0000, base;
  logic [31:0] o_data = 32'h0, i_data;
  logic o_ready, i_valid, armed, evt, pd, s_out, s_in, ext_clk;
  logic [15:0] cnt, stamp;
  logic [2:0] sel;
  logic [PW-1:0] p_out, p_oeb, wire_v, rx_last;
  int err_total = 0;
  int n_checks = 0;
  tiop_row_t rows [5] = '{'{32'h8421c3a5, 1'b0, 1'b0, 8'h00}, '{32'h0f1e2d3c, 1'b1, 1'b0, 8'h00},
    '{32'hffff0000, 1'b0, 1'b0, 8'h0f}, '{32'h12345678, 1'b1, 1'b0, 8'hf0}, '{32'hdeadbeef, 1'b0, 1'b1, 8'h00}};

  always #2.5 core_clk = ~core_clk;
  tiop_port #(.PORT_W(PW)) dut (.core_clk(core_clk), .rst_b(rst_b), .cfg_dir_out(dir_out),
    .cfg_open_drain(od), .cfg_link_en(link), .cfg_pin_taken(taken), .cfg_strobe_in_en(s_in_en),
    .cfg_strobe_out_en(s_out_en), .cfg_cond_mode(cmode), .cfg_cond_value(cval), .cfg_cb_src_ext(cb_ext),
    .cfg_cb_div(cb_div), .cpu_clk_set(clk_set), .cpu_clk_value(clk_val), .cpu_time_set(t_set),
    .cpu_time_value(t_val), .cpu_out_valid(o_valid), .cpu_out_data(o_data), .cpu_out_ready(o_ready),
    .cpu_in_valid(i_valid), .cpu_in_data(i_data), .cpu_in_ready(i_ready), .port_count(cnt),
    .port_stamp(stamp), .port_time_armed(armed), .port_clk_sel(sel), .port_event(evt), .pin_in(wire_v),
    .pin_out(p_out), .pin_oe_b(p_oeb), .pin_pd_en(pd), .strobe_in(s_in), .strobe_out(s_out),
    .ext_clk_pin(ext_clk));
  tiop_ext_dev #(.PORT_W(PW)) far (.core_clk(core_clk), .pin_out(p_out), .pin_oe_b(p_oeb), .pin_pd_en(pd),
    .strobe_out(s_out), .src_data(src_data), .src_en(src_en), .rdy_lvl(rdy), .ext_run(ext_run),
    .pin_wire(wire_v), .strobe_in(s_in), .ext_clk_pin(ext_clk), .rx_last(rx_last));

  // Helpers: inputs always move 1 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic check32(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wait_evt(input int lim);
    for (int k = 0; k < lim && evt !== 1'b1; k++) cyc(1);
    check32("event", 32'h1, evt);
  endtask
  task automatic send(input logic [31:0] w);
    o_valid = 1'b1;
    o_data = w;
    for (int k = 0; k < 60 && o_ready !== 1'b1; k++) cyc(1);
    cyc(1);
    o_valid = 1'b0;
  endtask
  // One word out; slices follow the ticks, two cycles apart
  task automatic out_word(input logic [31:0] w, input logic [PW-1:0] tk, input logic odv);
    logic [PW-1:0] s;
    send(w);
    wait_evt(40);
    for (int i = 0; i < 4; i++) begin
      s = w[i*PW +: PW];
      check32("pin wire", s | tk, wire_v);
      check32("pin oe", odv ? (s | tk) : tk, p_oeb);
      check32("strobe", 32'h1, s_out);
      cyc(2);
    end
    cyc(4);
    check32("far side word", w[31:24] | tk, rx_last);
  endtask
  task automatic take_in(input logic [31:0] w);
    for (int k = 0; k < 120 && i_valid !== 1'b1; k++) cyc(1);
    check32("in valid", 32'h1, i_valid);
    check32("in word", w, i_data);
    i_ready = 1'b1;
    cyc(1);
    i_ready = 1'b0;
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs about 500 cycles, this allows twenty times that
  initial begin
    #50000;
    err_total++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    cyc(1);
    check32("reset pull-down", 32'h1, pd);
    check32("reset select", 32'h0, sel);
    repeat (2) @(posedge core_clk);
    #1 rst_b = 1'b1;
    cyc(2);
    check32("pull-down off", 32'h0, pd);
    foreach (rows[r]) begin
      od = rows[r].odv;
      link = rows[r].lk;
      taken = rows[r].tk;
      cyc(2);
      out_word(rows[r].w, rows[r].lk ? 8'hff : rows[r].tk, rows[r].odv);
    end
    // Timed output: word must wait for the counter to reach the target
    link = 1'b0;
    t_val = cnt + 16'h0014;
    t_set = 1'b1;
    cyc(1);
    t_set = 1'b0;
    send(32'h5a5aa5a5);
    cyc(26);
    check32("held until time", 32'h0, o_ready);
    wait_evt(40);
    check32("stamp", t_val, stamp);
    check32("armed", 32'h0, armed);
    cyc(10);
    // Input with every condition mode; constant pins make any word equal
    cmode = tiop_pkg::tiop_cond_t'(2'h3);
    dir_out = 1'b0;
    src_en = 1'b1;
    src_data = 8'h3c;
    cyc(4); // Old output slice leaves the synchroniser first
    for (int m = 0; m < 3; m++) begin
      cmode = tiop_pkg::tiop_cond_t'(m);
      cval = (m == 2) ? 8'h11 : 8'h3c;
      take_in(32'h3c3c3c3c);
    end
    cmode = tiop_pkg::tiop_cond_t'(2'h3);
    repeat (2) begin
      cyc(40);
      if (i_valid === 1'b1) take_in(32'h3c3c3c3c);
    end
    cyc(40);
    check32("never condition", 32'h0, i_valid);
    // Strobe-gated input; taken pins read as zero
    cmode = tiop_pkg::COND_NONE;
    s_in_en = 1'b1;
    taken = 8'h0f;
    src_data = 8'h5a;
    cyc(40);
    check32("no strobe no word", 32'h0, i_valid);
    rdy = 1'b1;
    take_in(32'h50505050);
    // Clock block 3 on the external pin, divided by two
    cb_ext = 6'h08;
    cb_div[3] = 8'h01;
    ext_run = 1'b1;
    clk_val = 3'h3;
    clk_set = 1'b1;
    cyc(1);
    clk_set = 1'b0;
    check32("select ext block", 32'h3, sel);
    base = cnt;
    cyc(80);
    check32("ext ticks", 32'h1, (cnt - base) > 16'h0002 && (cnt - base) < 16'h0008);
    ext_run = 1'b0;
    cyc(10);
    base = cnt;
    cyc(40);
    check32("ext clock still", base, cnt);
    clk_val = 3'h7;
    clk_set = 1'b1;
    cyc(1);
    clk_set = 1'b0;
    check32("bad select refused", 32'h3, sel);
    // Second reset in mid-run
    rst_b = 1'b0;
    cyc(1);
    check32("mid reset pull-down", 32'h1, pd);
    check32("mid reset select", 32'h0, sel);
    rst_b = 1'b1;
    cyc(2);
    check32("mid release pull-down", 32'h0, pd);
    cyc(2);
    report_and_stop();
  end
endmodule
